// [core/i2r_pkg.sv]
/*
  i2r_pkg: constants and types shared by both ends of the two-wire
  register port. Assumes a 50 MHz core clock on the host end.
*/
package i2r_pkg;
  // ----------------------------------------------------------------
  // bus addresses and framing
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR_LO = 7'h54; // address-select strap low
  localparam logic [6:0] DEV_ADDR_HI = 7'h55; // address-select strap high
  localparam logic RW_WRITE = 1'b0; // direction bit, write
  localparam logic RW_READ = 1'b1; // direction bit, read
  localparam logic [3:0] ACK_BIT = 4'h8; // bit index of the ack slot
  localparam logic MODE_TWO_WIRE = 1'b0; // interface-choose strap level
  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  localparam int REG_DEPTH = 32; // implemented registers
  localparam logic [7:0] REG_RST = 8'h00; // reset value of each register
  localparam logic [7:0] PTR_RST = 8'h00; // reset value of the pointer
  // ----------------------------------------------------------------
  // timing of the host end
  // ----------------------------------------------------------------
  localparam int CORE_PERIOD_NS = 20; // core_clk period
  localparam int SCL_PERIOD_NS = 2500; // least scl period, 400 kHz
  // one scl period is four quarter slots; a least time rounds up
  localparam int QTR_CYC = (SCL_PERIOD_NS + 4 * CORE_PERIOD_NS - 1) / (4 * CORE_PERIOD_NS);
  localparam logic [5:0] QTR_LAST = 6'(QTR_CYC - 1);
  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_REGA, ST_WDATA, ST_RDATA} i2r_dst_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} i2r_hst_t;
  typedef enum logic [1:0] {STP_START, STP_WR, STP_RD, STP_STOP} i2r_step_t;
endpackage

// [core/i2r_if.sv]
/*
  i2r_if: the two-wire link between host end and device end.
  Assumes pull-ups on both lines; levels are resolved from the enables.
*/
`timescale 1ns/1ps
interface i2r_if;
  logic host_scl_o; // host clock drive value
  logic host_scl_oe; // host pulls clock
  logic host_sda_o; // host data drive value
  logic host_sda_oe; // host pulls data
  logic dev_sda_o; // device data drive value
  logic dev_sda_oe; // device pulls data
  logic scl; // resolved clock line
  logic sda; // resolved data line
  // open-drain wired-and with pull-up
  assign scl = host_scl_oe ? host_scl_o : 1'b1;
  assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
  modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input sda);
  modport dev (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface

// [core/i2r_regfile.sv]
/*
  i2r_regfile: byte-wide register storage of the device end, in the
  serial clock domain. Assumes writes come from the port engine only.
*/
`timescale 1ns/1ps
module i2r_regfile (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // write side
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  // read side
  input wire logic [7:0] raddr,
  output logic [7:0] rdata
);
  import i2r_pkg::*;

  logic [7:0] mem_r [REG_DEPTH]; // storage, one flop byte per register

  // addresses beyond the storage are holes: writes drop, reads give zero
  function automatic logic in_map(input logic [7:0] a);
    in_map = 32'(a) < REG_DEPTH;
  endfunction

  // ----------------------------------------------------------------
  // write port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        mem_r[i] <= REG_RST;
      end
    end else if (we && in_map(waddr)) begin
      mem_r[waddr[4:0]] <= wdata;
    end
  end

  // read is combinational so the byte is ready at the ack edge
  assign rdata = in_map(raddr) ? mem_r[raddr[4:0]] : 8'h00;
endmodule

// [core/i2r_dev.sv]
/*
  i2r_dev: device end of the two-wire register port. Its serial logic
  runs on the link clock scl; register writes are handed to core_clk.
  Assumes the straps are static and that the master does not stretch.
*/
`timescale 1ns/1ps
// How it works
// - two-wire mode only while mode strap low
// - clock pin is scl, data pin is sda
// - answer 54h or 55h per address strap
// - change sda only while scl low
// - start/stop are sda edges with scl high
// - master frames; busy from start until stop
// - repeated start restarts address decoding
// - eight bits msb first, then ack slot
// - transmitter releases, receiver pulls on ninth
// - addressed receiver acknowledges every byte
// - first byte: address plus direction bit
// - write: register byte, then value byte
// - value lands at rising edge of ack
// - read preceded by register-setting write phase
// - pointer advances after every data byte
module i2r_dev (
  // link to the master
  i2r_if.dev link,
  // core clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // straps
  input wire logic mode_sel,
  input wire logic addr_sel,
  // register updates, core clock domain
  output logic reg_wr,
  output logic [7:0] reg_waddr,
  output logic [7:0] reg_wdata,
  output logic bus_busy
);
  import i2r_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [1:0] mode_sync_r; // strap synchroniser, scl domain
  logic [1:0] asel_sync_r; // strap synchroniser, scl domain
  logic two_wire; // two-wire mode selected
  logic [6:0] my_addr; // decoded own address
  logic start_ev_r; // toggles on every start, sda fall clock
  logic start_busy_r; // busy half, set side
  logic stop_busy_r; // busy half, clear side
  logic start_seen_r; // last start taken by the scl domain
  logic restart; // start pending for the next scl edge
  i2r_dst_t st_r; // transaction state
  logic [3:0] bit_r; // bit index within the byte, 8 = ack slot
  logic [7:0] rx_r; // shift register for received bits
  logic [7:0] tx_r; // byte being sent on reads
  logic [7:0] ptr_r; // register pointer
  logic [7:0] rd_addr; // pointer or pointer plus one
  logic [7:0] rd_data; // register read data
  logic ack_slot; // this scl period is the ack slot
  logic addr_hit; // received address is ours
  logic wr_en; // store the value byte now
  logic sda_oe_r; // data pull, changed on scl fall
  logic wr_tgl_r; // write event toggle, scl domain
  logic [7:0] wr_addr_r; // held write address for the crossing
  logic [7:0] wr_data_r; // held write data for the crossing
  logic [2:0] wr_sync_r; // toggle synchroniser plus edge stage
  logic [1:0] busy_sync_r; // busy level synchroniser
  logic reg_wr_r; // one-cycle write strobe
  logic [7:0] reg_waddr_r; // write address to the core
  logic [7:0] reg_wdata_r; // write data to the core
  logic bus_busy_r; // bus busy level to the core

  // ----------------------------------------------------------------
  // straps
  // ----------------------------------------------------------------
  // straps are pins, so two flops on scl; static, so the delay is moot
  always_ff @(posedge link.scl or negedge rstn) begin
    if (!rstn) begin
      mode_sync_r <= {2{~MODE_TWO_WIRE}};
      asel_sync_r <= 2'b00;
    end else begin
      mode_sync_r <= {mode_sync_r[0], mode_sel};
      asel_sync_r <= {asel_sync_r[0], addr_sel};
    end
  end

  // the four-wire port shares these pins; its serial output is unused
  assign two_wire = mode_sync_r[1] == MODE_TWO_WIRE;
  assign my_addr = asel_sync_r[1] ? DEV_ADDR_HI : DEV_ADDR_LO;

  // ----------------------------------------------------------------
  // start and stop detection
  // ----------------------------------------------------------------
  // the data line clocks these flops: a start or stop has no scl edge,
  // so no scl-domain sampler could see it
  always_ff @(negedge link.sda or negedge rstn) begin
    if (!rstn) begin
      start_ev_r <= 1'b0;
      start_busy_r <= 1'b0;
    end else if (link.scl) begin
      start_ev_r <= ~start_ev_r;
      start_busy_r <= ~stop_busy_r;
    end
  end

  // stop makes both halves equal again, which frees the bus
  always_ff @(posedge link.sda or negedge rstn) begin
    if (!rstn) begin
      stop_busy_r <= 1'b0;
    end else if (link.scl) begin
      stop_busy_r <= start_busy_r;
    end
  end

  // the start toggle settles during the scl high and low that follow,
  // long before the next scl edge reads it
  assign restart = start_ev_r ^ start_seen_r;

  // ----------------------------------------------------------------
  // bit counter and receive shifter
  // ----------------------------------------------------------------
  always_ff @(posedge link.scl or negedge rstn) begin
    if (!rstn) begin
      start_seen_r <= 1'b0;
      bit_r <= 4'h0;
      rx_r <= 8'h00;
    end else if (restart) begin
      // first address bit arrives on the edge after a start
      start_seen_r <= start_ev_r;
      bit_r <= 4'h1;
      rx_r <= {rx_r[6:0], link.sda};
    end else if (bit_r == ACK_BIT) begin
      bit_r <= 4'h0;
    end else begin
      bit_r <= bit_r + 4'h1;
      rx_r <= {rx_r[6:0], link.sda};
    end
  end

  assign ack_slot = (bit_r == ACK_BIT) && !restart;
  assign addr_hit = two_wire && (rx_r[7:1] == my_addr);

  // ----------------------------------------------------------------
  // transaction state
  // ----------------------------------------------------------------
  always_ff @(posedge link.scl or negedge rstn) begin
    if (!rstn) begin
      st_r <= ST_IDLE;
    end else if (restart) begin
      // a start always opens decoding; the strap is judged from the next scl edge on,
      // because its synchroniser only settles on the frame's own edges
      st_r <= ST_ADDR;
    end else if (!two_wire) begin
      st_r <= ST_IDLE;
    end else if (ack_slot) begin
      unique case (st_r)
        ST_IDLE: st_r <= ST_IDLE;
        // other addresses are ignored until the next start
        ST_ADDR: begin
          if (!addr_hit) begin
            st_r <= ST_IDLE;
          end else if (rx_r[0] == RW_READ) begin
            st_r <= ST_RDATA;
          end else begin
            st_r <= ST_REGA;
          end
        end
        ST_REGA: st_r <= ST_WDATA;
        ST_WDATA: st_r <= ST_WDATA;
        // master nack (line high) ends the read
        ST_RDATA: st_r <= link.sda ? ST_IDLE : ST_RDATA;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pointer, transmit byte and storage
  // ----------------------------------------------------------------
  // the read port looks one ahead while a read runs, so the next byte
  // is ready at the ack edge without a second port
  assign rd_addr = (st_r == ST_RDATA) ? ptr_r + 8'h01 : ptr_r;
  assign wr_en = ack_slot && two_wire && (st_r == ST_WDATA);

  always_ff @(posedge link.scl or negedge rstn) begin
    if (!rstn) begin
      ptr_r <= PTR_RST;
      tx_r <= 8'h00;
    end else if (ack_slot) begin
      unique case (st_r)
        ST_REGA: ptr_r <= rx_r;
        ST_WDATA: ptr_r <= ptr_r + 8'h01;
        ST_ADDR: begin
          if (addr_hit && rx_r[0] == RW_READ) begin
            tx_r <= rd_data;
          end
        end
        ST_RDATA: begin
          ptr_r <= ptr_r + 8'h01;
          tx_r <= rd_data;
        end
        ST_IDLE: tx_r <= tx_r;
      endcase
    end
  end

  // value lands on the rising scl edge inside each value byte's ack slot
  i2r_regfile u_regs (
    .clk(link.scl),
    .rstn(rstn),
    .we(wr_en),
    .waddr(ptr_r),
    .wdata(rx_r),
    .raddr(rd_addr),
    .rdata(rd_data)
  );

  // ----------------------------------------------------------------
  // data line drive
  // ----------------------------------------------------------------
  // updated on the falling scl edge so the line only moves while low
  always_ff @(negedge link.scl or negedge rstn) begin
    if (!rstn) begin
      sda_oe_r <= 1'b0;
    end else if (!two_wire || restart) begin
      sda_oe_r <= 1'b0;
    end else if (bit_r == ACK_BIT) begin
      // ack as receiver; a read leaves the slot to the master
      sda_oe_r <= (st_r == ST_ADDR && addr_hit) || st_r == ST_REGA ||
                  st_r == ST_WDATA;
    end else if (st_r == ST_RDATA) begin
      sda_oe_r <= ~tx_r[3'd7 - bit_r[2:0]];
    end else begin
      sda_oe_r <= 1'b0;
    end
  end

  assign link.dev_sda_oe = sda_oe_r;
  assign link.dev_sda_o = 1'b0; // open drain: only ever pulls low

  // ----------------------------------------------------------------
  // write hand-over to the core domain
  // ----------------------------------------------------------------
  // address and data are held from the write edge until the next byte,
  // many core cycles, so they are stable when the toggle arrives
  always_ff @(posedge link.scl or negedge rstn) begin
    if (!rstn) begin
      wr_tgl_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end else if (wr_en) begin
      wr_tgl_r <= ~wr_tgl_r;
      wr_addr_r <= ptr_r;
      wr_data_r <= rx_r;
    end
  end

  // toggle synchroniser; only stages 1 and 2 feed the edge compare
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_sync_r <= 3'b000;
      busy_sync_r <= 2'b00;
    end else begin
      wr_sync_r <= {wr_sync_r[1:0], wr_tgl_r};
      busy_sync_r <= {busy_sync_r[0], start_busy_r ^ stop_busy_r};
    end
  end

  // core-side outputs, all from flops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_wr_r <= 1'b0;
      reg_waddr_r <= 8'h00;
      reg_wdata_r <= 8'h00;
      bus_busy_r <= 1'b0;
    end else begin
      reg_wr_r <= wr_sync_r[2] ^ wr_sync_r[1];
      bus_busy_r <= busy_sync_r[1];
      if (wr_sync_r[2] ^ wr_sync_r[1]) begin
        reg_waddr_r <= wr_addr_r;
        reg_wdata_r <= wr_data_r;
      end
    end
  end

  assign reg_wr = reg_wr_r;
  assign reg_waddr = reg_waddr_r;
  assign reg_wdata = reg_wdata_r;
  assign bus_busy = bus_busy_r;
endmodule

// [core/i2r_host.sv]
/*
  i2r_host: bus master end. Makes scl from core_clk by a divider and
  runs one single-byte register write or read per command.
  Assumes the device never stretches the clock.
*/
`timescale 1ns/1ps
module i2r_host (
  // core clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // link to the device
  i2r_if.host link,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic cmd_dev_sel,
  input wire logic [7:0] cmd_reg,
  input wire logic [7:0] cmd_wdata,
  // response
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_nack
);
  import i2r_pkg::*;

  logic [1:0] sda_sync_r; // data line synchroniser
  logic [5:0] q_cnt_r; // quarter-slot divider
  logic tick; // end of a quarter slot
  logic [1:0] ph_r; // quarter within the current step
  i2r_hst_t st_r; // engine state
  i2r_step_t kind_r; // kind of the current byte step
  logic [2:0] step_r; // step within the transaction
  logic [3:0] bit_r; // bit within the byte, 8 = ack slot
  logic [7:0] sh_r; // transmit shifter
  logic [7:0] rx_r; // receive shifter
  logic is_rd_r, dsel_r; // latched command kind and address strap copy
  logic [7:0] reg_r, wd_r; // latched register and value
  logic nack_r; // a byte went unacknowledged
  logic accept, step_end; // command taken; last quarter of a step
  logic scl_oe_r, sda_oe_r, rdy_r, rsp_valid_r; // pins and handshake
  logic [7:0] rsp_rdata_r;
  logic rsp_nack_r;
  i2r_step_t nk; // kind of the next step

  // write: start, addr, reg, value, stop
  // read: start, addr, reg, start, addr+read, one byte nacked, stop
  function automatic i2r_step_t step_kind(input logic rd, input logic [2:0] s);
    if (s == 3'd0 || (rd && s == 3'd3)) begin
      step_kind = STP_START;
    end else if (rd && s == 3'd5) begin
      step_kind = STP_RD;
    end else if (s < (rd ? 3'd5 : 3'd4)) begin
      step_kind = STP_WR;
    end else begin
      step_kind = STP_STOP;
    end
  endfunction

  function automatic logic [7:0] step_byte(input logic [2:0] s);
    unique case (s)
      3'd1: step_byte = {dsel_r ? DEV_ADDR_HI : DEV_ADDR_LO, RW_WRITE};
      3'd2: step_byte = reg_r;
      3'd4: step_byte = {dsel_r ? DEV_ADDR_HI : DEV_ADDR_LO, RW_READ};
      default: step_byte = wd_r;
    endcase
  endfunction

  assign tick = q_cnt_r == QTR_LAST;
  assign accept = st_r == H_IDLE && cmd_valid && rdy_r;
  assign step_end = tick && ph_r == 2'd3;
  assign nk = step_kind(is_rd_r, step_r + 3'd1);

  // ----------------------------------------------------------------
  // synchroniser, divider and quarter phase
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sda_sync_r <= 2'b11;
      q_cnt_r <= 6'h00;
      ph_r <= 2'd0;
    end else begin
      sda_sync_r <= {sda_sync_r[0], link.sda};
      q_cnt_r <= tick ? 6'h00 : q_cnt_r + 6'h01;
      if (st_r == H_IDLE) begin
        ph_r <= 2'd0;
      end else if (tick) begin
        ph_r <= ph_r + 2'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= H_IDLE;
      kind_r <= STP_START;
      step_r <= 3'd0;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      {is_rd_r, dsel_r, reg_r, wd_r} <= 18'h00000;
    end else if (accept) begin
      {is_rd_r, dsel_r, reg_r, wd_r} <= {cmd_read, cmd_dev_sel, cmd_reg, cmd_wdata};
      st_r <= H_START;
      kind_r <= STP_START;
      step_r <= 3'd0;
    end else if (step_end) begin
      if (st_r == H_BIT && bit_r != ACK_BIT) begin
        bit_r <= bit_r + 4'h1;
        sh_r <= {sh_r[6:0], 1'b0};
      end else if (st_r == H_STOP) begin
        st_r <= H_IDLE;
      end else if (st_r != H_IDLE) begin
        step_r <= step_r + 3'd1;
        kind_r <= nk;
        bit_r <= 4'h0;
        sh_r <= step_byte(step_r + 3'd1);
        st_r <= nk == STP_START ? H_START : nk == STP_STOP ? H_STOP : H_BIT;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drive: bit data moves in quarter 0 while scl is low; start and stop move it in quarter 2 with scl high
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (tick) begin
      unique case (st_r)
        H_IDLE: {scl_oe_r, sda_oe_r} <= 2'b00;
        H_START: begin
          if (ph_r == 2'd0) sda_oe_r <= 1'b0;
          if (ph_r == 2'd1) scl_oe_r <= 1'b0;
          if (ph_r == 2'd2) sda_oe_r <= 1'b1;
          if (ph_r == 2'd3) scl_oe_r <= 1'b1;
        end
        H_BIT: begin
          // ack slot and read bits are released; the one read byte is nacked
          if (ph_r == 2'd0) sda_oe_r <= kind_r == STP_WR && bit_r != ACK_BIT && !sh_r[7];
          if (ph_r == 2'd1) scl_oe_r <= 1'b0;
          if (ph_r == 2'd3) scl_oe_r <= 1'b1;
        end
        H_STOP: begin
          if (ph_r == 2'd0) sda_oe_r <= 1'b1;
          if (ph_r == 2'd1) scl_oe_r <= 1'b0;
          if (ph_r == 2'd2) sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  assign link.host_scl_oe = scl_oe_r;
  assign link.host_scl_o = 1'b0;
  assign link.host_sda_oe = sda_oe_r;
  assign link.host_sda_o = 1'b0;

  // ----------------------------------------------------------------
  // receive, ack check and response
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_r <= 8'h00;
      nack_r <= 1'b0;
      rdy_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= 8'h00;
      rsp_nack_r <= 1'b0;
    end else begin
      rsp_valid_r <= st_r == H_STOP && step_end;
      if (accept) begin
        nack_r <= 1'b0;
        rdy_r <= 1'b0;
      end else if (st_r == H_IDLE) begin
        rdy_r <= 1'b1;
      end else if (st_r == H_BIT && tick && ph_r == 2'd2) begin
        if (bit_r != ACK_BIT) rx_r <= {rx_r[6:0], sda_sync_r[1]};
        if (bit_r == ACK_BIT && kind_r == STP_WR && sda_sync_r[1]) nack_r <= 1'b1;
      end
      if (st_r == H_STOP && step_end) begin
        rsp_rdata_r <= rx_r;
        rsp_nack_r <= nack_r;
      end
    end
  end

  assign cmd_ready = rdy_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_rdata = rsp_rdata_r;
  assign rsp_nack = rsp_nack_r;
endmodule

// [tb/i2r_link_sva.sv]
/* i2r_link_sva: assertions on the two-wire link between the ends.
   assumes core_clk samples the link far faster than scl moves. */
`timescale 1ns/1ps
module i2r_link_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // straps
  input wire logic mode_sel,
  input wire logic addr_sel,
  // link
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  import i2r_pkg::*;
  logic scl_r, sda_r, busy_r, rd_r, hit_r; // delayed lines, frame state
  logic [3:0] bit_r; // scl rises in this byte
  logic [1:0] byte_r; // bytes since start, saturating
  logic [7:0] sh_r; // bits taken in
  logic rise, sta, sto, hit;
  assign rise = scl & ~scl_r;
  assign sta = scl & scl_r & sda_r & ~sda;
  assign sto = scl & scl_r & ~sda_r & sda;
  assign hit = sh_r[7:1] == (addr_sel ? DEV_ADDR_HI : DEV_ADDR_LO) && mode_sel == MODE_TWO_WIRE;
  // -----------------------------------------------
  // line history and bus occupancy
  // -----------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      {scl_r, sda_r, busy_r} <= 3'h6;
    end else begin
      {scl_r, sda_r} <= {scl, sda};
      busy_r <= sta | (busy_r & ~sto);
    end
  end
  // bit and byte position; restarts cleanly on a repeated start
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      {bit_r, byte_r, sh_r, rd_r, hit_r} <= '0;
    end else if (sta) begin
      {bit_r, byte_r} <= '0;
    end else if (rise && bit_r == ACK_BIT) begin
      bit_r <= 4'h0;
      byte_r <= byte_r + {1'b0, byte_r != 2'h3};
      if (byte_r == 2'h0) begin
        {hit_r, rd_r} <= {hit, sh_r[0]};
      end
    end else if (rise) begin
      sh_r <= {sh_r[6:0], sda};
      bit_r <= bit_r + 4'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device moved data with scl high");
  a_start_by_host: assert property (sta |-> host_sda_oe)
    else $error("start not made by host");
  a_stop_dev_free: assert property (sto |-> !dev_sda_oe)
    else $error("device held data at stop");
  a_no_contention: assert property (dev_sda_oe && scl |-> !host_sda_oe)
    else $error("both ends pull data");
  a_addr_match: assert property (rise && byte_r == 2'h0 && bit_r == ACK_BIT |-> dev_sda_oe == hit)
    else $error("address ack wrong");
  a_ack_data: assert property (rise && byte_r != 2'h0 && bit_r == ACK_BIT |-> dev_sda_oe == (hit_r && !rd_r))
    else $error("data ack slot wrong");
  a_quiet_bits: assert property (rise && bit_r != ACK_BIT && !(hit_r && rd_r && byte_r != 2'h0) |-> !dev_sda_oe)
    else $error("device drove a host bit");
  a_busy_span: assert property (dev_sda_oe |-> busy_r)
    else $error("device drove an idle bus");
endmodule

// [tb/tb_i2c_register_slave.sv]
/* tb_i2c_register_slave: host end commands the device end over the link.
   assumes one command at a time; expectations come from a register model. */
`timescale 1ns/1ps
module tb_i2c_register_slave;
  import i2r_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, mode_sel = 1'b0, addr_sel = 1'b0;
  logic cmd_valid = 1'b0, cmd_read = 1'b0, cmd_dev_sel = 1'b0;
  logic [7:0] cmd_reg = 8'h00, cmd_wdata = 8'h00, a, ptr_exp;
  logic cmd_ready, rsp_valid, rsp_nack, reg_wr, bus_busy;
  logic [7:0] rsp_rdata, reg_waddr, reg_wdata;
  logic [9:0] rq[$], e; // responses: read flag, nack, data
  logic [15:0] wq[$]; // core-side register writes
  logic [7:0] mem[REG_DEPTH]; // register model
  logic [31:0] lfsr = 32'd88142;
  int mismatches = 0, total_checks = 0, cyc = 0;
  i2r_if link ();
  i2r_dev i_i2r_dev (.link(link.dev), .core_clk, .rstn, .mode_sel, .addr_sel,
    .reg_wr, .reg_waddr, .reg_wdata, .bus_busy);
  i2r_host i_i2r_host (.core_clk, .rstn, .link(link.host), .cmd_valid, .cmd_ready,
    .cmd_read, .cmd_dev_sel, .cmd_reg, .cmd_wdata, .rsp_valid, .rsp_rdata, .rsp_nack);
  i2r_link_sva i_i2r_link_sva (.core_clk, .rstn, .mode_sel, .addr_sel,
    .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe), .scl(link.scl),
    .sda(link.sda));
  always #10 core_clk = ~core_clk;
  // hang guard: about fifteen commands of under five thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      final_report();
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic cmp(input logic [15:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one command; notes expectations, checks busy mid-frame and after while the mode strap is low
  task automatic cmd(input logic rd, sel, input logic [7:0] ra, wd, input logic ack);
    @(negedge core_clk);
    {cmd_valid, cmd_read, cmd_dev_sel, cmd_reg, cmd_wdata} = {1'b1, rd, sel, ra, wd};
    rq.push_back({rd && ack, !ack, rd && ack && ra < REG_DEPTH ? mem[ra] : 8'h00});
    // an acked write to a hole still strobes the core side, only storage drops it
    if (!rd && ack) wq.push_back({ra, wd});
    if (!rd && ack && ra < REG_DEPTH) mem[ra] = wd;
    if (ack) ptr_exp = ra + 8'h01;
    @(posedge core_clk iff cmd_ready);
    @(negedge core_clk);
    cmd_valid = 1'b0;
    repeat (1000) @(negedge core_clk);
    if (!mode_sel) cmp({15'h0, bus_busy}, 16'h1);
    @(posedge core_clk iff cmd_ready);
    @(negedge core_clk);
    if (!mode_sel) cmp({15'h0, bus_busy}, 16'h0);
    cmp({8'h00, i_i2r_dev.ptr_r}, {8'h00, ptr_exp});
  endtask
  // result watchers take the oldest note off each queue
  // sampled on the falling edge, where the registered outputs have settled
  always @(negedge core_clk) begin
    if (rsp_valid) begin
      e = rq.size() ? rq.pop_front() : 10'hx;
      cmp({7'h0, rsp_nack, e[9] ? rsp_rdata : 8'h00}, {7'h0, e[8:0]});
    end
    if (reg_wr) cmp({reg_waddr, reg_wdata}, wq.size() ? wq.pop_front() : 16'hx);
  end
  initial begin
    foreach (mem[i]) mem[i] = REG_RST;
    repeat (2) @(negedge core_clk);
    rstn = 1'b1;
    // random registers plus the top one, each written then read back
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      a = i == 3 ? 8'h1f : {3'h0, lfsr[4:0]};
      cmd(1'b0, 1'b0, a, lfsr[15:8], 1'b1);
      cmd(1'b1, 1'b0, a, 8'h00, 1'b1);
    end
    cmd(1'b0, 1'b0, 8'h40, 8'h5a, 1'b1);
    cmd(1'b1, 1'b0, 8'h40, 8'h00, 1'b1);
    cmd(1'b0, 1'b1, 8'h03, 8'h77, 1'b0);
    addr_sel = 1'b1;
    cmd(1'b0, 1'b1, 8'h02, 8'h3c, 1'b1);
    cmd(1'b1, 1'b1, 8'h02, 8'h00, 1'b1);
    cmd(1'b1, 1'b0, 8'h02, 8'h00, 1'b0);
    mode_sel = 1'b1;
    cmd(1'b0, 1'b1, 8'h04, 8'h11, 1'b0);
    cmp(16'(rq.size() + wq.size()), 16'h0);
    final_report();
  end
endmodule
